// File: flash_mode_pkg.sv
// constants and types for flash programming mode access control
// Behaviour
// - flash is programmed or erased one byte at a time or up to 32 bytes in one parallel operation.
// - each sector is erased and programmed alone, other sectors untouched.
// - the size of sector 0 comes from a field of the nonvolatile option byte.
// - in the tool socket, sectors 0 and 1, option row and data eeprom are writable.
// - in board-level programming the same areas are writable while on the board.
// - in self-programming only sector 1 and data eeprom are writable, sector 0 and option row refused.
// - the tool enters the comm mode by a pin sequence while reset is low, and the device detects it.
// - entering the comm mode fetches the system memory reset vector.
// - the tool downloads driver code to ram over the data pin, which then runs from ram.
// - in self-programming sector 0 stays protected so a failed run can be recovered.
// - the programming pin is held high in reset, a pull-up keeps it high when floating.
`default_nettype none
package flash_mode_pkg;
   localparam int ADDR_W = 13;
   localparam int BATCH_MAX = 32;
   localparam logic [5:0] BATCH_MAX_V = 6'h20;
   localparam int SEC0_FIELD_W = 2;
   // sector 0 end address per option field value: 0.5k, 1k, 2k, 4k
   localparam logic [ADDR_W-1:0] SEC0_END_0 = 13'h01ff;
   localparam logic [ADDR_W-1:0] SEC0_END_1 = 13'h03ff;
   localparam logic [ADDR_W-1:0] SEC0_END_2 = 13'h07ff;
   localparam logic [ADDR_W-1:0] SEC0_END_3 = 13'h0fff;
   // entry sequence: data pattern sampled on rising link clock edges
   localparam int ENTRY_LEN = 8;
   localparam logic [7:0] ENTRY_PATTERN = 8'ha5;
   localparam logic [15:0] VEC_USER = 16'hfffe;
   localparam logic [15:0] VEC_SYSMEM = 16'hfffc;
   typedef enum logic [1:0] {
      MODE_USER,
      MODE_SOCKET,
      MODE_BOARD,
      MODE_SELF
   } prog_mode_t;
   typedef enum logic [1:0] {
      AREA_SEC0,
      AREA_SEC1,
      AREA_OPTION,
      AREA_EEPROM
   } area_t;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_LATCH,
      ST_BUSY
   } op_state_t;
endpackage
`default_nettype wire

// File: flash_program_mode_access.sv
// program mode entry and flash write/erase permission control
`default_nettype none
module flash_program_mode_access
   import flash_mode_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic PROG_SERIAL_CLOCK,
   input wire logic PROG_SERIAL_DATA_IN,
   output logic PROG_SERIAL_DATA_OUT,
   output logic PROG_SERIAL_DATA_OE,
   output logic PROG_PULLUP_EN,
   input wire logic PIN_RESET_N,
   input wire logic SOCKET_MODE,
   input wire logic SELF_PROG_REQ,
   input wire logic [SEC0_FIELD_W-1:0] OPT_SEC0_SIZE,
   input wire logic OPT_ROW_SEL,
   input wire logic EEPROM_SEL,
   input wire logic [ADDR_W-1:0] WR_ADDR,
   input wire logic WR_LATCH,
   input wire logic WR_START,
   input wire logic WR_ERASE,
   input wire logic WR_DONE,
   output logic WR_ACCEPT,
   output logic WR_REFUSED,
   output logic WR_BUSY,
   output logic [5:0] WR_COUNT,
   output logic [1:0] WR_AREA,
   output logic [1:0] PROG_MODE,
   output logic [15:0] BOOT_VECTOR,
   output logic BOOT_VALID,
   output logic RAM_EXEC
);

   ////////////////////////////////////////////////////////////////////
   function automatic area_t area_of(input logic [ADDR_W-1:0] a,
                                     input logic [SEC0_FIELD_W-1:0] f,
                                     input logic opt, input logic ee);
      logic [ADDR_W-1:0] lim;
      lim = SEC0_END_0;
      unique case (f)
         2'h0: lim = SEC0_END_0;
         2'h1: lim = SEC0_END_1;
         2'h2: lim = SEC0_END_2;
         2'h3: lim = SEC0_END_3;
      endcase
      if (opt) area_of = AREA_OPTION;
      else if (ee) area_of = AREA_EEPROM;
      else if (a <= lim) area_of = AREA_SEC0;
      else area_of = AREA_SEC1;
   endfunction

   function automatic logic allowed(input prog_mode_t m, input area_t ar);
      unique case (m)
         MODE_SOCKET: allowed = 1'b1;
         MODE_BOARD: allowed = 1'b1;
         // sector 0 keeps the recovery driver, never touched here
         MODE_SELF: allowed = (ar == AREA_SEC1) ||
                              (ar == AREA_EEPROM);
         MODE_USER: allowed = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // link domain: shift in data on link clock edges during reset
   logic [ENTRY_LEN-1:0] link_shift_r;
   logic link_match_r;
   always_ff @(posedge PROG_SERIAL_CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         link_shift_r <= '0;
         link_match_r <= 1'b0;
      end else begin
         link_shift_r <= {link_shift_r[ENTRY_LEN-2:0], PROG_SERIAL_DATA_IN};
         if ({link_shift_r[ENTRY_LEN-2:0], PROG_SERIAL_DATA_IN}
             == ENTRY_PATTERN)
            link_match_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin and level synchronisers, three stages, second and third agree
   logic [2:0] match_sync_r, rst_sync_r, self_sync_r;
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         match_sync_r <= '0;
         rst_sync_r <= '0;
         self_sync_r <= '0;
      end else begin
         match_sync_r <= {match_sync_r[1:0], link_match_r};
         rst_sync_r <= {rst_sync_r[1:0], PIN_RESET_N};
         self_sync_r <= {self_sync_r[1:0], SELF_PROG_REQ};
      end
   end
   logic match_s, pin_rst_hi, pin_rst_lo, self_s;
   assign match_s = match_sync_r[1] & match_sync_r[2];
   assign pin_rst_hi = rst_sync_r[1] & rst_sync_r[2];
   assign pin_rst_lo = ~rst_sync_r[1] & ~rst_sync_r[2];
   assign self_s = self_sync_r[1] & self_sync_r[2];

   ////////////////////////////////////////////////////////////////////
   // boot decision taken at release of the reset pin
   logic in_reset_r, comm_r, boot_valid_r;
   logic [15:0] boot_vec_r;
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         in_reset_r <= 1'b1;
         comm_r <= 1'b0;
         boot_valid_r <= 1'b0;
         boot_vec_r <= VEC_USER;
      end else if (pin_rst_lo) begin
         in_reset_r <= 1'b1;
         boot_valid_r <= 1'b0;
      end else if (pin_rst_hi && in_reset_r) begin
         in_reset_r <= 1'b0;
         boot_valid_r <= 1'b1;
         comm_r <= match_s;
         boot_vec_r <= match_s ? VEC_SYSMEM : VEC_USER;
      end
   end

   // ram execution one cycle after the boot decision selects the comm mode
   logic ram_exec_r;
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) ram_exec_r <= 1'b0;
      else if (!comm_r) ram_exec_r <= 1'b0;
      else if (boot_valid_r) ram_exec_r <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////
   prog_mode_t mode_r;
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) mode_r <= MODE_USER;
      else if (SOCKET_MODE) mode_r <= MODE_SOCKET;
      else if (comm_r) mode_r <= MODE_BOARD;
      else if (self_s && boot_valid_r) mode_r <= MODE_SELF;
      else mode_r <= MODE_USER;
   end

   ////////////////////////////////////////////////////////////////////
   // write batch: up to 32 bytes latched, all within one sector
   op_state_t st_r;
   logic [5:0] cnt_r;
   area_t area_r;
   logic acc_r, ref_r;
   area_t cur_area;
   logic ok;
   assign cur_area = area_of(WR_ADDR, OPT_SEC0_SIZE, OPT_ROW_SEL, EEPROM_SEL);
   assign ok = allowed(mode_r, cur_area);

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         st_r <= ST_IDLE;
         cnt_r <= '0;
         area_r <= AREA_SEC0;
         acc_r <= 1'b0;
         ref_r <= 1'b0;
      end else begin
         acc_r <= 1'b0;
         ref_r <= 1'b0;
         unique case (st_r)
            ST_IDLE: begin
               if (WR_LATCH || WR_START) begin
                  if (ok) begin
                     area_r <= cur_area;
                     acc_r <= 1'b1;
                     // erase or single byte go straight to busy
                     if (WR_START || WR_ERASE) st_r <= ST_BUSY;
                     else begin
                        st_r <= ST_LATCH;
                        cnt_r <= 6'h01;
                     end
                  end else ref_r <= 1'b1;
               end
            end
            ST_LATCH: begin
               if (WR_START) begin
                  st_r <= ST_BUSY;
                  acc_r <= 1'b1;
               end else if (WR_LATCH) begin
                  // a batch never spans sectors, others untouched
                  if (ok && cur_area == area_r &&
                      cnt_r < BATCH_MAX_V) begin
                     cnt_r <= cnt_r + 6'h01;
                     acc_r <= 1'b1;
                  end else ref_r <= 1'b1;
               end
            end
            ST_BUSY: begin
               if (WR_DONE) begin
                  st_r <= ST_IDLE;
                  cnt_r <= '0;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign WR_ACCEPT = acc_r;
   assign WR_REFUSED = ref_r;
   assign WR_BUSY = (st_r == ST_BUSY);
   assign WR_COUNT = cnt_r;
   assign WR_AREA = area_r;
   assign PROG_MODE = mode_r;
   assign BOOT_VECTOR = boot_vec_r;
   assign BOOT_VALID = boot_valid_r;
   assign RAM_EXEC = ram_exec_r;
   // device never drives data pin during entry; pull-up always on
   assign PROG_SERIAL_DATA_OUT = 1'b0;
   assign PROG_SERIAL_DATA_OE = 1'b0;
   assign PROG_PULLUP_EN = 1'b1;
endmodule
`default_nettype wire

// File: flash_program_mode_access_asserts.sv
// assertion checker for program mode access control
`default_nettype none
module flash_program_mode_access_asserts
   import flash_mode_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic PROG_SERIAL_DATA_OE,
   input wire logic PROG_PULLUP_EN,
   input wire logic [SEC0_FIELD_W-1:0] OPT_SEC0_SIZE,
   input wire logic OPT_ROW_SEL,
   input wire logic EEPROM_SEL,
   input wire logic [ADDR_W-1:0] WR_ADDR,
   input wire logic WR_LATCH,
   input wire logic WR_START,
   input wire logic WR_DONE,
   input wire logic WR_ACCEPT,
   input wire logic WR_REFUSED,
   input wire logic WR_BUSY,
   input wire logic [5:0] WR_COUNT,
   input wire logic [1:0] PROG_MODE,
   input wire logic [15:0] BOOT_VECTOR,
   input wire logic RAM_EXEC
);
default clocking @(posedge CLK_SYS); endclocking
default disable iff (!RSTN);
// busy requests are dropped silently, so leave them out
wire logic req = (WR_LATCH || WR_START) && !WR_BUSY;
wire logic [ADDR_W-1:0] s0_end = OPT_SEC0_SIZE[1] ?
   (OPT_SEC0_SIZE[0] ? SEC0_END_3 : SEC0_END_2) :
   (OPT_SEC0_SIZE[0] ? SEC0_END_1 : SEC0_END_0);
wire logic self_m = PROG_MODE == MODE_SELF;
////////////////////////////////////////////////////////////////////////////
a_pin_released: assert property (!PROG_SERIAL_DATA_OE && PROG_PULLUP_EN)
   else $error("data pin driven or pull-up off");
a_self_sec0_lock: assert property (req && self_m && !OPT_ROW_SEL &&
   !EEPROM_SEL && WR_ADDR <= s0_end |=> WR_REFUSED)
   else $error("sector 0 write not refused");
a_self_opt_lock: assert property (req && self_m && OPT_ROW_SEL |=> WR_REFUSED)
   else $error("option row write not refused");
a_board_first: assert property (req && WR_LATCH && PROG_MODE == MODE_BOARD &&
   WR_COUNT == 6'h00 |=> WR_ACCEPT && WR_COUNT == 6'h01)
   else $error("first latch not taken");
a_batch_cap: assert property (WR_COUNT <= BATCH_MAX_V)
   else $error("batch over size");
a_full_refuse: assert property (req && WR_LATCH &&
   WR_COUNT == BATCH_MAX_V |=> WR_REFUSED)
   else $error("extra byte not refused");
a_done_clear: assert property (WR_BUSY && WR_DONE |->
   ##[1:2] !WR_BUSY && WR_COUNT == 6'h00)
   else $error("busy not cleared");
a_sysmem_vec: assert property ($rose(RAM_EXEC) |-> BOOT_VECTOR == VEC_SYSMEM)
   else $error("wrong vector in comm mode");
a_one_answer: assert property (!(WR_ACCEPT && WR_REFUSED))
   else $error("accept and refuse together");
c_comm: cover property ($rose(RAM_EXEC));
c_full: cover property (WR_COUNT == BATCH_MAX_V);
c_self_ref: cover property (self_m && WR_REFUSED);
endmodule
`default_nettype wire

// File: flash_program_mode_access_bench.sv
// bench for program mode access control
`default_nettype none
module flash_program_mode_access_bench
   import flash_mode_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rstn = 1'b0, sock = 1'b0, selfp = 1'b0, opt = 1'b0;
   logic ee = 1'b0, lat = 1'b0, st = 1'b0, ers = 1'b0, done = 1'b0;
   logic sclk, sdat, pin_n, acc, rf, busy, bval, rex, dout, doe, pu;
   logic [1:0] osz = 2'h0;
   logic [12:0] addr = 13'h0000;
   logic [5:0] cnt;
   logic [1:0] mode;
   logic [1:0] area;
   logic [15:0] vec;
   int error_cnt = 0;
   int checked = 0;
   always #25 clk = ~clk;
   prog_tool_model tool (.sclk(sclk), .sdata(sdat), .pin_n(pin_n));
   flash_program_mode_access dut (.CLK_SYS(clk), .RSTN(rstn),
      .PROG_SERIAL_CLOCK(sclk), .PROG_SERIAL_DATA_IN(sdat),
      .PROG_SERIAL_DATA_OUT(dout), .PROG_SERIAL_DATA_OE(doe),
      .PROG_PULLUP_EN(pu), .PIN_RESET_N(pin_n), .SOCKET_MODE(sock),
      .SELF_PROG_REQ(selfp), .OPT_SEC0_SIZE(osz), .OPT_ROW_SEL(opt),
      .EEPROM_SEL(ee), .WR_ADDR(addr), .WR_LATCH(lat), .WR_START(st),
      .WR_ERASE(ers), .WR_DONE(done), .WR_ACCEPT(acc), .WR_REFUSED(rf),
      .WR_BUSY(busy), .WR_COUNT(cnt), .WR_AREA(area), .PROG_MODE(mode),
      .BOOT_VECTOR(vec), .BOOT_VALID(bval), .RAM_EXEC(rex));
   task cmp(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t %h %h", $time, g, e);
      end
   endtask
   task req(input logic [12:0] a, input logic s, input logic ok);
      @(posedge clk);
      addr <= a;
      lat <= !s;
      st <= s;
      @(posedge clk);
      lat <= 1'b0;
      st <= 1'b0;
      #1;
      cmp(acc, ok);
      cmp(rf, !ok);
   endtask
   task fin();
      @(posedge clk);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      @(posedge clk);
      #1;
      cmp(busy, 1'b0);
      cmp(cnt, 6'h00);
   endtask
   task settle();
      repeat (8) @(posedge clk);
      #1;
   endtask
////////////////////////////////////////////////////////////////////////////
   task t_entry();
      tool.boot(ENTRY_PATTERN);
      settle();
      cmp(vec, VEC_SYSMEM);
      cmp(rex, 1'b1);
      cmp(mode, MODE_BOARD);
      cmp(pu, 1'b1);
      cmp(doe, 1'b0);
      cmp(dout, 1'b0);
      for (int i = 0; i < BATCH_MAX; i++) req(13'(i), 1'b0, 1'b1);
      req(13'h0020, 1'b0, 1'b0);
      req(13'h1000, 1'b0, 1'b0);
      req(13'h0000, 1'b1, 1'b1);
      cmp(busy, 1'b1);
      fin();
   endtask
   task t_user();
      @(posedge clk);
      rstn <= 1'b0;
      settle();
      rstn <= 1'b1;
      // the bitwise inverse of the pattern must not open the link mode
      tool.boot(8'h5a);
      settle();
      cmp(vec, VEC_USER);
      cmp(rex, 1'b0);
      cmp(bval, 1'b1);
      req(13'h1000, 1'b0, 1'b0);
   endtask
   task t_self();
      osz <= 2'h3;
      selfp <= 1'b1;
      settle();
      cmp(mode, MODE_SELF);
      req(13'h0800, 1'b0, 1'b0);
      opt <= 1'b1;
      req(13'h1800, 1'b0, 1'b0);
      opt <= 1'b0;
      req(13'h1800, 1'b0, 1'b1);
      cmp(area, AREA_SEC1);
      req(13'h1801, 1'b1, 1'b1);
      fin();
      ee <= 1'b1;
      ers <= 1'b1;
      req(13'h0000, 1'b1, 1'b1);
      fin();
   endtask
   task t_socket();
      selfp <= 1'b0;
      sock <= 1'b1;
      ee <= 1'b0;
      ers <= 1'b0;
      opt <= 1'b1;
      settle();
      cmp(mode, MODE_SOCKET);
      req(13'h0000, 1'b0, 1'b1);
      req(13'h0000, 1'b1, 1'b1);
      fin();
   endtask
   task wrap_up();
      if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      settle();
      rstn <= 1'b1;
      t_entry();
      t_user();
      t_self();
      t_socket();
      wrap_up();
   end
   initial begin
      #400000;
      error_cnt++;
      wrap_up();
   end
endmodule
bind flash_program_mode_access flash_program_mode_access_asserts chk (
   .CLK_SYS, .RSTN, .PROG_SERIAL_DATA_OE, .PROG_PULLUP_EN, .OPT_SEC0_SIZE,
   .OPT_ROW_SEL, .EEPROM_SEL, .WR_ADDR, .WR_LATCH, .WR_START, .WR_DONE,
   .WR_ACCEPT, .WR_REFUSED, .WR_BUSY, .WR_COUNT, .PROG_MODE, .BOOT_VECTOR,
   .RAM_EXEC);
`default_nettype wire

// File: prog_tool_model.sv
// model of the external programming tool on the two-wire link
`default_nettype none
module prog_tool_model (
   output logic sclk,
   output logic sdata,
   output logic pin_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sclk = 1'b0;
      sdata = 1'b1;
      pin_n = 1'b0;
   end
   // clock stands still between frames, data left at pull-up level
   task boot(input logic [7:0] pat);
      pin_n = 1'b0;
      #1037;
      for (int i = 7; i >= 0; i--) begin
         sdata = pat[i];
         #80 sclk = 1'b1;
         #80 sclk = 1'b0;
      end
      sdata = 1'b1;
      #333 pin_n = 1'b1;
   endtask
endmodule
`default_nettype wire
